/* File: hdl/ots_trim_ctrl.sv */
`timescale 1ns/1ps
`include "ots_regs.svh"

module ots_trim_ctrl #(
  parameter int ADR_W = 32
) (
  input wire logic clk_i, // oscillator-derived clock, 50 mhz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write enable
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic [ADR_W-1:0] adr_i, // wishbone byte address
  input wire logic [31:0] dat_i, // wishbone write data
  output logic [31:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  input wire logic stop_mode_i, // stop power mode request pin
  output ots_pkg::ots_code_t regulator_level_o, // regulator trim
  output logic [1:0] coarse_range_sel_o, // coarse range
  output ots_pkg::ots_code_t swept_code_out_o, // fine code to osc
  output logic osc_enable_o, // oscillator enable
  output logic osc_ready_o // oscillator settled
);
  import ots_pkg::*;

  // byte address 4*0xa003 needs 18 address bits
  if (ADR_W < 18 || ADR_W > 32)
  begin : g_adr_check
    $error("ots_trim_ctrl: ADR_W must be 18..32");
  end

  localparam logic [3:0] SETTLE_LAST = 4'(`OTS_SETTLE_CYCLES - 1);

  // offset limit for an amplitude code
  function automatic ots_offset_t amp_limit(input logic [1:0] amp);
    amp_limit = 7'(7'h04 << amp); // RULE7
  endfunction : amp_limit

  // fine code plus signed offset, saturated
  function automatic ots_code_t clip_sum(input ots_code_t base,
                                         input ots_offset_t off);
    logic signed [9:0] sum;
    sum = $signed({2'b00, base}) + 10'($signed(off));
    if (sum < 10'sd0)
      clip_sum = 8'h00; // RULE11
    else if (sum > 10'sd255)
      clip_sum = 8'hff; // RULE11
    else
      clip_sum = sum[7:0];
  endfunction : clip_sum

  // word decode; misaligned or foreign addresses map to none
  function automatic ots_sel_e decode(input logic [ADR_W-1:0] adr);
    logic [ADR_W-3:0] idx;
    idx = adr[ADR_W-1:2];
    decode = OTS_SEL_NONE;
    if (adr[1:0] == 2'b00)
    begin
      if (idx == (ADR_W-2)'(`OTS_IDX_REG_LEVEL))
        decode = OTS_SEL_LEVEL;
      else if (idx == (ADR_W-2)'(`OTS_IDX_COARSE))
        decode = OTS_SEL_COARSE;
      else if (idx == (ADR_W-2)'(`OTS_IDX_FINE))
        decode = OTS_SEL_FINE;
      else if (idx == (ADR_W-2)'(`OTS_IDX_STATUS))
        decode = OTS_SEL_STATUS;
    end
  endfunction : decode

  ots_state_s q;
  ots_state_s d;

  logic [3:0] rate;
  logic [1:0] amp;
  ots_offset_t lim;
  logic bus_req;
  ots_sel_e bus_sel;

  // field views of the coarse/spread register
  assign rate = q.coarse[`OTS_RATE_MSB:`OTS_RATE_LSB];
  assign amp = q.coarse[`OTS_AMP_MSB:`OTS_AMP_LSB];
  assign lim = amp_limit(amp);
  assign bus_req = cyc_i && stb_i && !q.ack;
  assign bus_sel = decode(adr_i);

  // next-state logic for the whole block
  always_comb
  begin
    logic [1:0] hold_last;
    logic signed [6:0] off_s;
    logic signed [6:0] lim_s;
    hold_last = 2'd1;
    off_s = $signed(q.offset);
    lim_s = $signed(lim);
    d = q;

    // stop pin: three flops, act once the last two agree
    d.stop_s1 = stop_mode_i;
    d.stop_s2 = q.stop_s1;
    d.stop_s3 = q.stop_s2;
    if (q.stop_s2 == q.stop_s3)
      d.stop_lvl = q.stop_s3;

    // one flop drives the enable, so it cannot glitch
    d.osc_en = !q.stop_lvl; // RULE4 RULE5
    if (!q.osc_en)
    begin
      d.settle = 4'h0;
      d.osc_ready = 1'b0;
    end
    else if (!q.osc_ready)
    begin
      if (q.settle == SETTLE_LAST)
        d.osc_ready = 1'b1; // RULE5
      else
        d.settle = q.settle + 4'h1;
    end

    // wishbone slave: one wait state, ack for one cycle
    d.ack = bus_req;
    if (bus_req && we_i && sel_i[0])
    begin
      case (bus_sel)
        OTS_SEL_LEVEL: d.level = dat_i[7:0]; // RULE1
        OTS_SEL_COARSE: d.coarse = dat_i[7:0]; // RULE13
        OTS_SEL_FINE: d.fine = dat_i[7:0];
        default: ;
      endcase
    end
    d.rdata = 32'h0;
    if (bus_req && !we_i)
    begin
      case (bus_sel)
        OTS_SEL_LEVEL: d.rdata[7:0] = q.level;
        OTS_SEL_COARSE: d.rdata[7:0] = q.coarse;
        OTS_SEL_STATUS:
        begin
          d.rdata[`OTS_ST_SWEPT_MSB:`OTS_ST_SWEPT_LSB] = q.swept;
          d.rdata[`OTS_ST_READY] = q.osc_ready;
          d.rdata[`OTS_ST_ENABLE] = q.osc_en;
          d.rdata[`OTS_ST_SWEEP] = (q.sweep != OTS_SW_OFF);
        end
        default: d.rdata = 32'h0; // fine trim is write-only
      endcase
    end

    // turning points and zero are held one interval longer
    if (q.offset == 7'h00 || off_s >= lim_s || off_s <= -lim_s)
      hold_last = 2'd2; // RULE10

    // triangular sweep generator
    case (q.sweep)
      OTS_SW_OFF:
      begin
        d.offset = 7'h00; // RULE15
        d.rate_cnt = 4'h0;
        d.hold = 2'd0;
        if (rate != 4'h0 && q.osc_en)
          d.sweep = OTS_SW_UP; // RULE6
      end
      OTS_SW_UP, OTS_SW_DOWN:
      begin
        if (q.osc_en)
        begin
          if (q.rate_cnt != rate - 4'h1)
            d.rate_cnt = q.rate_cnt + 4'h1; // RULE9
          else
          begin
            d.rate_cnt = 4'h0;
            if (q.hold != hold_last)
              d.hold = q.hold + 2'd1;
            else
            begin
              d.hold = 2'd0;
              // one code per step; reverse at the limit
              if (q.sweep == OTS_SW_UP)
              begin
                if (off_s >= lim_s)
                begin
                  d.sweep = OTS_SW_DOWN;
                  d.offset = q.offset - 7'h01; // RULE15
                end
                else
                  d.offset = q.offset + 7'h01; // RULE15
              end
              else
              begin
                if (off_s <= -lim_s)
                begin
                  d.sweep = OTS_SW_UP;
                  d.offset = q.offset + 7'h01;
                end
                else
                  d.offset = q.offset - 7'h01;
              end
            end
          end
        end
        // a zero rate ends the sweep at once
        if (rate == 4'h0)
        begin
          d.sweep = OTS_SW_OFF; // RULE6
          d.offset = 7'h00; // RULE15
          d.rate_cnt = 4'h0;
          d.hold = 2'd0;
        end
      end
      default:
      begin
        d.sweep = OTS_SW_OFF;
        d.offset = 7'h00;
      end
    endcase

    // code to the oscillator, passed straight (not inverted)
    if (rate == 4'h0)
      d.swept = q.fine; // RULE6 RULE12
    else
      d.swept = clip_sum(q.fine, q.offset); // RULE8 RULE11

    // defaults win over everything on reset
    if (rst_i)
    begin
      d = '0;
      d.level = `OTS_RST_REG_LEVEL; // RULE2
      d.coarse = `OTS_RST_COARSE; // RULE2
      d.fine = `OTS_RST_FINE; // RULE2
      d.swept = `OTS_RST_FINE;
      d.sweep = OTS_SW_OFF;
      d.osc_en = 1'b1; // oscillator runs out of reset
    end
  end

  // single state register
  always_ff @(posedge clk_i)
  begin
    q <= d;
  end

  // outputs come straight from state flops
  assign dat_o = q.rdata;
  assign ack_o = q.ack;
  assign regulator_level_o = q.level; // RULE1
  assign coarse_range_sel_o = q.coarse[`OTS_RANGE_MSB:`OTS_RANGE_LSB];
  assign swept_code_out_o = q.swept;
  assign osc_enable_o = q.osc_en;
  assign osc_ready_o = q.osc_ready;

  // helper: cycles between sweeps leaving zero upward
  logic [11:0] per_cnt;
  logic per_valid;
  logic per_mark;
  logic [11:0] per_expect;
  assign per_mark = q.offset == 7'h01 && d.offset == 7'h01 &&
                    q.sweep == OTS_SW_UP && q.rate_cnt == 4'h0 &&
                    q.hold == 2'd0;
  assign per_expect = 12'(4 * rate * (2 * lim + 1));

  // restart the measurement on any disturbance
  always_ff @(posedge clk_i)
  begin
    if (rst_i || rate == 4'h0 || !q.osc_en || d.coarse != q.coarse)
    begin
      per_cnt <= 12'h0;
      per_valid <= 1'b0;
    end
    else if (per_mark)
    begin
      per_cnt <= 12'h1;
      per_valid <= 1'b1;
    end
    else
      per_cnt <= per_cnt + 12'h1;
  end

  // helper: cycles the enable has stood high, saturating
  logic [3:0] en_run;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !osc_enable_o)
      en_run <= 4'h0;
    else if (en_run != 4'hf)
      en_run <= en_run + 4'h1;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_reset_defaults: assert property ($past(rst_i) |-> // RULE2
    regulator_level_o == 8'hff && q.coarse == 8'h01 && q.fine == 8'h8e)
    else $error("trim registers not at defaults after reset");

  a_level_write: assert property ( // RULE1
    bus_req && we_i && sel_i[0] && bus_sel == OTS_SEL_LEVEL |=>
    regulator_level_o == $past(dat_i[7:0]) && ack_o)
    else $error("regulator level does not follow written code");

  a_stop_disables: assert property ( // RULE4
    stop_mode_i [*5] |=> !osc_enable_o)
    else $error("oscillator still enabled in stop mode");

  a_run_enables: assert property ( // RULE4
    !stop_mode_i [*5] |=> osc_enable_o)
    else $error("oscillator not enabled outside stop mode");

  a_ready_settle: assert property ( // RULE5
    en_run == 4'(`OTS_SETTLE_CYCLES) |-> osc_ready_o)
    else $error("oscillator ready not raised after settle time");

  a_ready_early: assert property ( // RULE5
    $rose(osc_enable_o) |-> !osc_ready_o [*3])
    else $error("oscillator ready raised too early");

  a_bypass_pass: assert property ( // RULE6
    rate == 4'h0 && $past(rate) == 4'h0 |->
    swept_code_out_o == $past(q.fine))
    else $error("fine code not passed through with sweep off");

  a_offset_limit: assert property ( // RULE7
    $stable(q.coarse) && $past($signed(q.offset) <= $signed(lim) &&
    $signed(q.offset) >= -$signed(lim)) |->
    $signed(q.offset) <= $signed(lim) && $signed(q.offset) >= -$signed(lim))
    else $error("sweep offset beyond selected amplitude");

  a_swept_sum: assert property ( // RULE8
    rate != 4'h0 && $stable(rate) |=>
    swept_code_out_o == clip_sum($past(q.fine), $past(q.offset)))
    else $error("swept code not fine code plus clipped offset");

  a_rate_interval: assert property ( // RULE9
    q.sweep != OTS_SW_OFF && rate != 4'h0 && q.offset != d.offset &&
    d.sweep != OTS_SW_OFF |-> q.rate_cnt == rate - 4'h1)
    else $error("offset stepped off the rate interval");

  a_sweep_period: assert property ( // RULE10
    per_mark && per_valid |-> per_cnt == per_expect)
    else $error("sweep period differs from 4*rate*(2*amp+1)");

  a_step_one: assert property ( // RULE15
    q.sweep != OTS_SW_OFF && d.sweep != OTS_SW_OFF |->
    d.offset == q.offset || d.offset == q.offset + 7'h01 ||
    d.offset == q.offset - 7'h01)
    else $error("offset moved by more than one code");

  a_off_restart: assert property ( // RULE15
    rate == 4'h0 |=> q.offset == 7'h00 && q.sweep == OTS_SW_OFF)
    else $error("offset not cleared with sweep disabled");

  c_top_reached: cover property (
    q.sweep == OTS_SW_UP ##1 q.sweep == OTS_SW_DOWN);
  c_bottom_reached: cover property (
    q.sweep == OTS_SW_DOWN ##1 q.sweep == OTS_SW_UP);
  c_clip_low: cover property (rate != 4'h0 && swept_code_out_o == 8'h00);
  c_stop_cycle: cover property ($fell(osc_enable_o) ##[1:50] osc_ready_o);

endmodule : ots_trim_ctrl

/* File: hdl/ots_regs.svh */
// What this block and its software do
// RULE1: regulator level follows the 8-bit code, ff highest, 00 lowest.
// RULE2: any reset loads regulator ff, coarse/spread 01, fine trim 8e.
// RULE3: software reloads calibrated trims after every reset.
// RULE4: internal oscillator runs in every state except stop mode.
// RULE5: glitch-free enable; ready flag after about ten cycles.
// RULE6: sweep rate zero disables spreading; fine code passes unchanged.
// RULE7: amplitude field picks offset limit: 11=32, 10=16, 01=8, 00=4.
// RULE8: with spreading on, output is fine code plus time-varying offset.
// RULE9: sweep rate sets the update interval in oscillator cycles.
// RULE10: one full sweep lasts 4 x rate x (2 x amplitude + 1) cycles.
// RULE11: swept code saturates at 0 and 255 instead of wrapping.
// RULE12: fine code is passed uninverted; 00 fastest, ff slowest.
// RULE13: two-bit coarse field selects one of four frequency ranges.
// RULE14: software calibrates: coarse 01, fine 00/ff/7f, binary search.
// RULE15: offset steps by one in a triangle, restarts at zero when off.
`ifndef OTS_REGS_SVH
`define OTS_REGS_SVH

// register indices; byte address is four times the index
`define OTS_IDX_REG_LEVEL 16'ha000
`define OTS_IDX_COARSE 16'ha001
`define OTS_IDX_FINE 16'ha002
`define OTS_IDX_STATUS 16'ha003

// reset values
`define OTS_RST_REG_LEVEL 8'hff
`define OTS_RST_COARSE 8'h01
`define OTS_RST_FINE 8'h8e

// coarse/spread register fields
`define OTS_RATE_MSB 7
`define OTS_RATE_LSB 4
`define OTS_AMP_MSB 3
`define OTS_AMP_LSB 2
`define OTS_RANGE_MSB 1
`define OTS_RANGE_LSB 0

// status register fields
`define OTS_ST_SWEPT_MSB 7
`define OTS_ST_SWEPT_LSB 0
`define OTS_ST_READY 8
`define OTS_ST_ENABLE 9
`define OTS_ST_SWEEP 10

// oscillator settle time in oscillator cycles
`define OTS_SETTLE_CYCLES 10

`endif

/* File: hdl/ots_pkg.sv */
package ots_pkg;

  typedef logic [7:0] ots_code_t;
  typedef logic [6:0] ots_offset_t;

  // gray along off -> up -> down
  typedef enum logic [1:0] {
    OTS_SW_OFF = 2'b00,
    OTS_SW_UP = 2'b01,
    OTS_SW_DOWN = 2'b11
  } ots_sweep_e;

  typedef enum logic [2:0] {
    OTS_SEL_NONE = 3'h0,
    OTS_SEL_LEVEL = 3'h1,
    OTS_SEL_COARSE = 3'h2,
    OTS_SEL_FINE = 3'h3,
    OTS_SEL_STATUS = 3'h4
  } ots_sel_e;

  typedef struct packed {
    logic stop_s1;
    logic stop_s2;
    logic stop_s3;
    logic stop_lvl;
    logic osc_en;
    logic [3:0] settle;
    logic osc_ready;
    ots_code_t level;
    ots_code_t coarse;
    ots_code_t fine;
    logic ack;
    logic [31:0] rdata;
    ots_sweep_e sweep;
    logic [3:0] rate_cnt;
    logic [1:0] hold;
    ots_offset_t offset;
    ots_code_t swept;
  } ots_state_s;

endpackage : ots_pkg

/* File: bench/ots_osc_model.sv */
`timescale 1ns/1ps

module ots_osc_model (
  input wire logic [7:0] level_i, // regulator code
  input wire logic [1:0] range_i, // coarse range
  input wire logic [7:0] fine_i, // code at the oscillator
  input wire logic enable_i, // oscillator enable
  output logic [15:0] mv_o, // regulator output, millivolts
  output logic [15:0] khz_o // oscillator frequency, khz
);
  // linear level, 00 lowest and ff highest
  // product needs 32 bits before the divide, or ff wraps
  assign mv_o = 16'(32'h0672 + 32'(level_i) * 32'h012c / 32'h00ff);
  // higher range is faster, higher fine code is slower; no clock when off
  always_comb
  begin
    if (!enable_i)
      khz_o = 16'h0000;
    else
      khz_o = 16'h36b0 + 16'(range_i) * 16'h0ed8 -
              16'(fine_i) * 16'h001c;
  end
endmodule : ots_osc_model

/* File: bench/tb.sv */
`timescale 1ns/1ps

module tb;
  import ots_pkg::*;
  localparam logic [31:0] A_LVL = 32'h00028000;
  localparam logic [31:0] A_CRS = 32'h00028004;
  localparam logic [31:0] A_FIN = 32'h00028008;
  localparam logic [31:0] A_STS = 32'h0002800c;
  localparam logic [31:0] A_BAD = 32'h00028010;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic stop_mode_i = 1'b0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] adr_i = 32'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rdat;
  logic ack_o, osc_enable_o, osc_ready_o;
  ots_code_t regulator_level_o, swept_code_out_o;
  logic [1:0] coarse_range_sel_o;
  logic [15:0] mv, khz;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  ots_trim_ctrl u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .stop_mode_i(stop_mode_i),
    .regulator_level_o(regulator_level_o),
    .coarse_range_sel_o(coarse_range_sel_o),
    .swept_code_out_o(swept_code_out_o),
    .osc_enable_o(osc_enable_o), .osc_ready_o(osc_ready_o)
  );

  ots_osc_model u_osc (
    .level_i(regulator_level_o), .range_i(coarse_range_sel_o),
    .fine_i(swept_code_out_o), .enable_i(osc_enable_o),
    .mv_o(mv), .khz_o(khz)
  );

  // 50 mhz clock
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // classic cycle; signals sampled before the edge's own updates land
  task automatic wb(input logic we, input logic [31:0] a,
    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    chk("ack", 1'b1, ack_o);
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    wb(1'b1, a, {24'h0, d}, 4'h1);
  endtask : wr

  task automatic t_reset();
    chk("level", 8'hff, regulator_level_o);
    chk("range", 2'h1, coarse_range_sel_o);
    chk("swept", 8'h8e, swept_code_out_o);
    chk("enable", 1'b1, osc_enable_o);
    chk("millivolts", 16'h079e, mv);
    wb(1'b0, A_LVL, 32'h0, 4'hf);
    chk("rd level", 32'hff, rdat);
    wb(1'b0, A_CRS, 32'h0, 4'hf);
    chk("rd coarse", 32'h01, rdat);
    wb(1'b0, A_FIN, 32'h0, 4'hf);
    chk("rd fine", 32'h0, rdat);
    wb(1'b0, A_STS, 32'h0, 4'hf);
    chk("rd status", 32'h28e, rdat & 32'h6ff);
  endtask : t_reset

  task automatic t_regs();
    wr(A_LVL, 8'h00);
    chk("level", 8'h00, regulator_level_o);
    chk("millivolts", 16'h0672, mv);
    wb(1'b1, A_LVL, 32'h55, 4'h0);
    chk("masked", 8'h00, regulator_level_o);
    wr(A_BAD, 8'h33);
    wb(1'b0, A_BAD, 32'h0, 4'hf);
    chk("rd unmapped", 32'h0, rdat);
    wr(A_CRS, 8'h03);
    chk("range", 2'h3, coarse_range_sel_o);
    wr(A_FIN, 8'h7f);
    repeat (2) @(posedge clk_i);
    chk("fine pass", 8'h7f, swept_code_out_o);
    wb(1'b0, A_FIN, 32'h0, 4'hf);
    chk("rd fine", 32'h0, rdat);
  endtask : t_regs

  // one full period after a warm-up: extremes and step count
  task automatic t_sweep(input logic [3:0] rate, input logic [1:0] amp,
    input logic [7:0] fine, input int mx, input int mn, input int steps);
    int p;
    int n;
    logic [7:0] hi, lo, prev;
    p = 4 * rate * (2 * (4 << amp) + 1);
    // park the sweep first so every run starts from offset zero
    wr(A_CRS, {4'h0, amp, 2'b01});
    wr(A_FIN, fine);
    wr(A_CRS, {rate, amp, 2'b01});
    repeat (p + 4) @(posedge clk_i);
    hi = swept_code_out_o;
    lo = hi;
    prev = hi;
    n = 0;
    repeat (p)
    begin
      @(posedge clk_i);
      if (swept_code_out_o !== prev)
        n++;
      if (swept_code_out_o > hi)
        hi = swept_code_out_o;
      if (swept_code_out_o < lo)
        lo = swept_code_out_o;
      prev = swept_code_out_o;
    end
    chk("sweep max", mx, hi);
    chk("sweep min", mn, lo);
    chk("sweep steps", steps, n);
  endtask : t_sweep

  // disabling drops back to the plain code; restart goes up from zero
  task automatic t_restart();
    int n;
    wr(A_CRS, 8'h01);
    wr(A_FIN, 8'h40);
    repeat (2) @(posedge clk_i);
    chk("sweep off", 8'h40, swept_code_out_o);
    wr(A_CRS, 8'h14);
    n = 0;
    while (swept_code_out_o === 8'h40 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("first step", 8'h41, swept_code_out_o);
    wr(A_CRS, 8'h01);
  endtask : t_restart

  task automatic t_stop();
    int n;
    stop_mode_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (osc_enable_o !== 1'b0 && n < 10);
    @(posedge clk_i);
    chk("stop enable", 1'b0, osc_enable_o);
    chk("stop ready", 1'b0, osc_ready_o);
    chk("stop khz", 16'h0, khz);
    stop_mode_i <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (osc_enable_o !== 1'b1 && n < 10);
    n = 0;
    while (osc_ready_o !== 1'b1 && n < 30)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("settle", 1'b1, n >= 9 && n <= 11);
  endtask : t_stop

  // calibration walk: coarse 01, probe 00/ff/7f, bisect towards 16 mhz
  task automatic t_calib();
    logic [15:0] k_fast, k_slow;
    logic [7:0] lo, hi, mid;
    wr(A_CRS, 8'h01);
    wr(A_FIN, 8'h00);
    @(posedge clk_i);
    k_fast = khz;
    wr(A_FIN, 8'hff);
    @(posedge clk_i);
    k_slow = khz;
    wr(A_FIN, 8'h7f);
    @(posedge clk_i);
    chk("khz order", 1'b1, k_fast > khz && khz > k_slow);
    lo = 8'h00;
    hi = 8'hff;
    while (hi - lo > 8'h01)
    begin
      mid = 8'((16'(lo) + 16'(hi)) >> 1);
      wr(A_FIN, mid);
      @(posedge clk_i);
      if (khz > 16'h3e80)
        lo = mid;
      else
        hi = mid;
    end
    chk("calibrated", 8'h40, lo);
  endtask : t_calib

  // mid-run reset: trims fall back, software then restores its values
  task automatic t_rerun();
    wr(A_LVL, 8'h5a);
    wr(A_CRS, 8'h26);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("level", 8'hff, regulator_level_o);
    chk("range", 2'h1, coarse_range_sel_o);
    chk("swept", 8'h8e, swept_code_out_o);
    chk("enable", 1'b1, osc_enable_o);
    chk("ready", 1'b0, osc_ready_o);
    wr(A_CRS, 8'h01);
    wr(A_FIN, 8'h40);
    repeat (2) @(posedge clk_i);
    chk("restored", 8'h40, swept_code_out_o);
  endtask : t_rerun

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_sweep(4'h1, 2'h0, 8'h80, 'h84, 'h7c, 16);
    t_sweep(4'h1, 2'h1, 8'h80, 'h88, 'h78, 32);
    t_sweep(4'h1, 2'h2, 8'h80, 'h90, 'h70, 64);
    t_sweep(4'h1, 2'h3, 8'h80, 'ha0, 'h60, 128);
    t_sweep(4'h3, 2'h1, 8'h80, 'h88, 'h78, 32);
    t_sweep(4'h1, 2'h3, 8'hff, 'hff, 'hdf, 64);
    t_sweep(4'h1, 2'h0, 8'h00, 'h04, 'h00, 8);
    t_restart();
    t_stop();
    t_calib();
    t_rerun();
    stop_test();
  end
endmodule : tb
